// [rtl/fli_params.svh]
// Constants of the fault latch and interrupt unit
// Summary of operation
// (R1) Interrupt output is high while any enabled, uncleared fault latch is set.
// (R2) Faults latch on occurrence; only the matching clear command releases a latch.
// (R3) A fault still present keeps the interrupt asserted after a clear addresses it.
// (R4) Clearing one of several pending faults leaves the interrupt high without a toggle.
// (R5) Query reply flags faults uncleared between last clear and this frame's start.
// (R6) A status query changes neither fault latches nor mask bits.
// (R7) Latches clear only after a clear command received without framing error.
// (R8) A fault arising during the clear frame keeps its latch set.
// (R9) Clearing takes effect on the chip-select rising edge ending the command.
// (R10) Host should clear only faults it saw in the preceding query reply.
// (R11) Top three bits zero is a query; low two bits select the returned register.
// (R12) Mask bit one lets its fault raise the interrupt; zero suppresses it.
// (R13) Two four-bit mask parts, written by opcodes 0010 and 0011 low nibbles.
// (R14) Clear commands share mask layout; each one bit clears that latch.
// (R15) Low part: overtemperature, desaturation, supply undervoltage, overcurrent.
// (R16) High part: phase error, framing error, write-after-lock error, reset event.
// (R17) Phase error is comparator XOR drive command, blanked in desaturation blanking.
// (R18) In full-on mode the phase error is blanked entirely.
// (R19) Reset event latched and enabled at reset, so interrupt rises after reset.
// (R20) Status register 0 is the reply to most commands.
// (R21) A frame whose bit count is not a multiple of eight is a framing error, discarded.
// (R22) While reset is low every latch but the reset event is cleared and both mask parts load all ones.
// (R23) A clear leaves a status bit set if its fault is present at that moment.
// (R24) Interrupt is the OR over eight sources of latch AND mask.
`ifndef FLI_PARAMS_SVH
`define FLI_PARAMS_SVH
`define FLI_MASK_RST 4'hF
`define FLI_LATCH_RST 8'h80
`define FLI_BIT_THERMAL_LIMIT 0
`define FLI_BIT_DESAT 1
`define FLI_BIT_LOW_SIDE_SUPPLY 2
`define FLI_BIT_OC 3
`define FLI_BIT_PHASE 4
`define FLI_BIT_FRAME 5
`define FLI_BIT_WERR 6
`define FLI_BIT_RESET 7
`define FLI_OP_QUERY 3'h0
`define FLI_OP_MASK_LO 4'h2
`define FLI_OP_MASK_HI 4'h3
`define FLI_OP_CLR_LO 4'h6
`define FLI_OP_CLR_HI 4'h7
`define FLI_SYNC_CS 0
`define FLI_SYNC_SCLK 1
`define FLI_SYNC_MOSI 2
`define FLI_SYNC_THERMAL_LIMIT 3
`define FLI_SYNC_DESAT 4
`define FLI_SYNC_LOW_SIDE_SUPPLY 5
`define FLI_SYNC_OC 6
`define FLI_SYNC_PHASE 7
`define FLI_SYNC_NUM 10
`endif

// [rtl/fli_pkg.sv]
// Types of the fault latch and interrupt unit
package fli_pkg;
  typedef enum logic [1:0] {
    FLI_IDLE = 2'b01,
    FLI_FRAME = 2'b10
  } fli_link_e;
  typedef logic [7:0] fli_word_t;
endpackage

// [rtl/fli_core.sv]
// Fault latching, interrupt masking and the serial command port
`timescale 1ns/1ns
`default_nettype none
`include "fli_params.svh"
module fli_core
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic thermal_limit_in,
  input wire logic desat_in,
  input wire logic low_side_supply_uv_in,
  input wire logic overcurrent_in,
  input wire logic [2:0] phase_comp_in,
  input wire logic [2:0] drive_cmd_in,
  input wire logic desat_blank_in,
  input wire logic full_on_mode,
  input wire logic write_lock_err_in,
  input wire logic [7:0] status1_in,
  input wire logic [7:0] status2_in,
  input wire logic [7:0] status3_in,
  output logic irq_out
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  wire [`FLI_SYNC_NUM-1:0] async_in;
  logic [`FLI_SYNC_NUM-1:0] sync1_q;
  logic [`FLI_SYNC_NUM-1:0] sync2_q;
  logic [`FLI_SYNC_NUM-1:0] sync3_q;
  logic [`FLI_SYNC_NUM-1:0] filt_q;
  logic [`FLI_SYNC_NUM-1:0] filt_prev_q;

  assign async_in = {phase_comp_in, overcurrent_in, low_side_supply_uv_in, desat_in,
                     thermal_limit_in, spi_mosi, spi_sclk, spi_cs_n};

  genvar gi;
  generate
    for (gi = 0; gi < `FLI_SYNC_NUM; gi = gi + 1)
    begin : g_sync
      // Idle level high only for chip select, so no false edge at release
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          sync1_q[gi] <= (gi == `FLI_SYNC_CS) ? 1'b1 : 1'b0;
          sync2_q[gi] <= (gi == `FLI_SYNC_CS) ? 1'b1 : 1'b0;
          sync3_q[gi] <= (gi == `FLI_SYNC_CS) ? 1'b1 : 1'b0;
          filt_q[gi] <= (gi == `FLI_SYNC_CS) ? 1'b1 : 1'b0;
          filt_prev_q[gi] <= (gi == `FLI_SYNC_CS) ? 1'b1 : 1'b0;
        end
        else
        begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          // A change counts only when stages two and three agree
          if (sync2_q[gi] == sync3_q[gi])
            filt_q[gi] <= sync3_q[gi];
          filt_prev_q[gi] <= filt_q[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Link edges and frame state
  // ****************************************
  wire cs_fall_w;
  wire cs_rise_w;
  wire sclk_rise_w;
  wire sclk_fall_w;
  assign cs_fall_w = filt_prev_q[`FLI_SYNC_CS] & ~filt_q[`FLI_SYNC_CS];
  assign cs_rise_w = ~filt_prev_q[`FLI_SYNC_CS] & filt_q[`FLI_SYNC_CS];
  assign sclk_rise_w = ~filt_prev_q[`FLI_SYNC_SCLK] & filt_q[`FLI_SYNC_SCLK];
  assign sclk_fall_w = filt_prev_q[`FLI_SYNC_SCLK] & ~filt_q[`FLI_SYNC_SCLK];

  fli_pkg::fli_link_e state_q;
  fli_pkg::fli_link_e state_d;
  logic [2:0] bit_cnt_q;
  logic any_bit_q;
  fli_pkg::fli_word_t rx_q;
  fli_pkg::fli_word_t tx_q;
  logic [1:0] reply_sel_q;

  wire in_frame_w;
  assign in_frame_w = (state_q == fli_pkg::FLI_FRAME);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      fli_pkg::FLI_IDLE:
      begin
        if (cs_fall_w)
          state_d = fli_pkg::FLI_FRAME;
      end
      fli_pkg::FLI_FRAME:
      begin
        if (cs_rise_w)
          state_d = fli_pkg::FLI_IDLE;
      end
      default:
        state_d = fli_pkg::FLI_IDLE;
    endcase
  end

  wire bit_take_w;
  wire shift_out_w;
  assign bit_take_w = in_frame_w & sclk_rise_w;
  assign shift_out_w = in_frame_w & sclk_fall_w;

  // Only the last eight bits are kept, so daisy-chained frames work
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= fli_pkg::FLI_IDLE;
      bit_cnt_q <= 3'h0;
      any_bit_q <= 1'b0;
      rx_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (cs_fall_w)
      begin
        bit_cnt_q <= 3'h0;
        any_bit_q <= 1'b0;
      end
      else if (bit_take_w)
      begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        any_bit_q <= 1'b1;
        rx_q <= {rx_q[6:0], filt_q[`FLI_SYNC_MOSI]};
      end
    end
  end

  // ****************************************
  // Command decode at frame end
  // ****************************************
  wire frame_ok_w;
  wire valid_end_w;
  wire bad_end_w;
  wire op_query_w;
  wire op_mask_lo_w;
  wire op_mask_hi_w;
  wire op_clr_lo_w;
  wire op_clr_hi_w;
  // An empty frame also counts as malformed
  assign frame_ok_w = any_bit_q & (bit_cnt_q == 3'h0); // R21
  assign valid_end_w = in_frame_w & cs_rise_w & frame_ok_w; // R7
  assign bad_end_w = in_frame_w & cs_rise_w & ~frame_ok_w; // R21
  assign op_query_w = (rx_q[7:5] == `FLI_OP_QUERY); // R11 R6
  assign op_mask_lo_w = valid_end_w & (rx_q[7:4] == `FLI_OP_MASK_LO); // R13
  assign op_mask_hi_w = valid_end_w & (rx_q[7:4] == `FLI_OP_MASK_HI); // R13
  assign op_clr_lo_w = valid_end_w & (rx_q[7:4] == `FLI_OP_CLR_LO); // R14
  assign op_clr_hi_w = valid_end_w & (rx_q[7:4] == `FLI_OP_CLR_HI); // R14

  // ****************************************
  // Fault sources
  // ****************************************
  wire [2:0] phase_mismatch_w;
  wire phase_err_w;
  fli_pkg::fli_word_t raw_w;
  assign phase_mismatch_w = filt_q[`FLI_SYNC_PHASE+2:`FLI_SYNC_PHASE] ^ drive_cmd_in; // R17
  assign phase_err_w = (|phase_mismatch_w) & ~desat_blank_in & ~full_on_mode; // R17 R18
  // Bit order follows the two mask parts
  assign raw_w = {1'b0, write_lock_err_in, bad_end_w, phase_err_w,
                  filt_q[`FLI_SYNC_OC], filt_q[`FLI_SYNC_LOW_SIDE_SUPPLY],
                  filt_q[`FLI_SYNC_DESAT], filt_q[`FLI_SYNC_THERMAL_LIMIT]}; // R15 R16

  // ****************************************
  // Latches, masks and interrupt
  // ****************************************
  fli_pkg::fli_word_t latch_q;
  fli_pkg::fli_word_t latch_d;
  fli_pkg::fli_word_t evt_q;
  logic [3:0] mask_lo_q;
  logic [3:0] mask_hi_q;
  logic irq_q;
  fli_pkg::fli_word_t clr_req_w;
  fli_pkg::fli_word_t clr_eff_w;
  fli_pkg::fli_word_t mask_w;

  assign mask_w = {mask_hi_q, mask_lo_q};
  assign clr_req_w = {(op_clr_hi_w ? rx_q[3:0] : 4'h0), (op_clr_lo_w ? rx_q[3:0] : 4'h0)}; // R14 R9
  // Present or mid-frame faults block their own clear
  assign clr_eff_w = clr_req_w & ~evt_q & ~raw_w; // R8 R23 R3
  // Set wins over clear in the same cycle
  assign latch_d = (latch_q & ~clr_eff_w) | raw_w; // R2

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latch_q <= `FLI_LATCH_RST; // R22 R19
      evt_q <= 8'h00;
      mask_lo_q <= `FLI_MASK_RST; // R22
      mask_hi_q <= `FLI_MASK_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      latch_q <= latch_d;
      // A fault in the frame-start cycle misses the reply, so it must still block
      if (cs_fall_w)
        evt_q <= raw_w; // R8
      else if (in_frame_w)
        evt_q <= evt_q | raw_w; // R8
      if (op_mask_lo_w)
        mask_lo_q <= rx_q[3:0]; // R13
      if (op_mask_hi_w)
        mask_hi_q <= rx_q[3:0]; // R13
      // Level output, so pending faults hold it high through a clear
      irq_q <= |(latch_q & mask_w); // R1 R12 R24 R4
    end
  end

  assign irq_out = irq_q;

  // ****************************************
  // Reply word
  // ****************************************
  fli_pkg::fli_word_t reply_w;
  assign reply_w = (reply_sel_q == 2'h0) ? latch_q :
                   (reply_sel_q == 2'h1) ? status1_in :
                   (reply_sel_q == 2'h2) ? status2_in : status3_in; // R20 R11

  // Reply is chosen by the previous valid frame and sampled at this frame's start
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reply_sel_q <= 2'h0;
      tx_q <= 8'h00;
    end
    else
    begin
      if (valid_end_w)
        reply_sel_q <= op_query_w ? rx_q[1:0] : 2'h0; // R11 R20
      if (cs_fall_w)
        tx_q <= reply_w; // R5
      else if (shift_out_w)
        tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign spi_miso = tx_q[7];
  assign spi_miso_oe = in_frame_w;

  // ****************************************
  // Checks
  // ****************************************
  logic boot_q;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      boot_q <= 1'b1;
    else
      boot_q <= 1'b0;
  end

  sequence s_valid_end;
    valid_end_w;
  endsequence

  sequence s_bad_end;
    bad_end_w;
  endsequence

  // Release edges skipped: flops there still hold their reset values
  chk_irq_follows_latch: assert property (@(posedge ref_clk) disable iff (!reset_n) // R24
    (!boot_q && (|(latch_q & mask_w))) |=> irq_q)
    else $error("interrupt low with enabled latched fault");

  chk_irq_needs_source: assert property (@(posedge ref_clk) disable iff (!reset_n) // R12
    irq_q |-> $past(|(latch_q & mask_w)))
    else $error("interrupt high with no enabled fault");

  chk_bad_frame_keeps: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
    s_bad_end |=> (((latch_q & $past(latch_q)) == $past(latch_q)) && latch_q[`FLI_BIT_FRAME]))
    else $error("malformed frame cleared a latch or missed framing error");

  chk_query_no_change: assert property (@(posedge ref_clk) disable iff (!reset_n) // R6
    s_valid_end ##0 op_query_w |=> ($stable(mask_w) && ((latch_q & $past(latch_q)) == $past(latch_q))))
    else $error("query changed latches or masks");

  chk_present_holds: assert property (@(posedge ref_clk) disable iff (!reset_n) // R3
    (raw_w != 8'h00) |=> ((latch_q & $past(raw_w)) == $past(raw_w)))
    else $error("present fault not latched");

  chk_clear_on_cs_rise: assert property (@(posedge ref_clk) disable iff (!reset_n) // R9
    (($past(latch_q) & ~latch_q) != 8'h00) |-> $past(valid_end_w && !op_query_w))
    else $error("latch cleared outside a valid clear frame end");

  chk_mid_frame_event: assert property (@(posedge ref_clk) disable iff (!reset_n) // R8
    s_valid_end |=> ((latch_q & $past(evt_q)) == $past(evt_q)))
    else $error("fault seen during frame was cleared");

  chk_clear_low_works: assert property (@(posedge ref_clk) disable iff (!reset_n) // R14
    s_valid_end ##0 (op_clr_lo_w && (raw_w == 8'h00) && (evt_q == 8'h00)) |=>
      ((latch_q[3:0] & $past(rx_q[3:0])) == 4'h0))
    else $error("low clear did not release latches");

  chk_mask_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
    s_valid_end ##0 op_mask_hi_w |=> (mask_hi_q == $past(rx_q[3:0])))
    else $error("high mask part not written");

  chk_full_on_blank: assert property (@(posedge ref_clk) disable iff (!reset_n) // R18
    full_on_mode |-> !phase_err_w)
    else $error("phase error in full-on mode");

  // Two cycles, as the release edge itself still holds the flops in reset
  chk_boot_irq: assert property (@(posedge ref_clk) disable iff (!reset_n) // R19
    boot_q |-> latch_q[`FLI_BIT_RESET] ##2 irq_q)
    else $error("no interrupt after reset release");

  sequence s_frame_start;
    cs_fall_w;
  endsequence

  chk_masked_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n) // R12
    ((latch_q & mask_w) == 8'h00) |=> !irq_q)
    else $error("interrupt high with every latched fault masked");

  chk_latch_no_drop: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
    (($past(latch_q) & ~latch_q) != 8'h00) |-> (($past(latch_q) & ~latch_q & ~$past(clr_req_w)) == 8'h00))
    else $error("latch released without a clear request");

  chk_reply_at_start: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
    s_frame_start ##0 (reply_sel_q == 2'h0) |=> (tx_q == $past(latch_q)))
    else $error("reply word not loaded from fault latches at frame start");

  chk_nonquery_reply: assert property (@(posedge ref_clk) disable iff (!reset_n) // R20
    s_valid_end ##0 !op_query_w |=> (reply_sel_q == 2'h0))
    else $error("command other than a query left a register select");

  chk_blank_phase: assert property (@(posedge ref_clk) disable iff (!reset_n) // R17
    desat_blank_in |-> !phase_err_w)
    else $error("phase error during desaturation blanking");

endmodule
`default_nettype wire

// [test/fli_host_model.sv]
// Host-side model: serial master with an interrupt input
`timescale 1ns/1ns
`default_nettype none
module fli_host_model
(
  input wire logic ref_clk,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic irq
);
  // ****************
  // Frame engine
  // ****************
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end

  // Reply bit taken late in the high half, well clear of its update
  task automatic xfer(input logic [7:0] c, input int n, output logic [7:0] r);
    int i;
    r = 8'h00;
    @(posedge ref_clk);
    spi_cs_n <= 1'b0;
    spi_mosi <= c[7];
    repeat (4) @(posedge ref_clk);
    for (i = 0; i < n; i++)
    begin
      spi_sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      r = {r[6:0], spi_miso};
      c = c << 1;
      spi_sclk <= 1'b0;
      spi_mosi <= c[7];
      repeat (4) @(posedge ref_clk);
    end
    spi_cs_n <= 1'b1;
    // Idle data line shows the inverse so a stale bit is never trusted
    spi_mosi <= ~spi_mosi;
    repeat (12) @(posedge ref_clk);
  endtask

  // Handler keyed on the level, clearing only what the query showed
  task automatic service(output logic [7:0] r);
    logic [7:0] d;
    r = 8'h00;
    if (irq === 1'b1)
    begin
      xfer(8'h00, 8, r);
      xfer({4'h6, r[3:0]}, 8, d);
      xfer({4'h7, r[7:4]}, 8, d);
    end
  endtask
endmodule
`default_nettype wire

// [test/fli_core_test.sv]
// Self-checking bench of the fault latch and interrupt unit
`timescale 1ns/1ns
`default_nettype none
module fli_core_test;
  logic ref_clk, reset_n, spi_cs_n, spi_sclk, spi_mosi, spi_miso, irq_out, spi_miso_oe, miso_line;
  logic blank, full_on, watch, drop;
  logic [7:0] flt, r, w;
  logic [2:0] pc, dc;
  logic [3:0] hi, nib;
  int error_cnt, check_count, b;

  fli_core i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .thermal_limit_in(flt[0]),
    .desat_in(flt[1]),
    .low_side_supply_uv_in(flt[2]), .overcurrent_in(flt[3]), .phase_comp_in(pc), .drive_cmd_in(dc),
    .desat_blank_in(blank), .full_on_mode(full_on), .write_lock_err_in(flt[6]), .status1_in(8'hA5),
    .status2_in(8'h3C), .status3_in(8'hC3), .irq_out(irq_out));
  fli_host_model i_host (.ref_clk(ref_clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .spi_miso(miso_line), .irq(irq_out));

  // Released line shows the inverse, so a bit read outside the frame is wrong
  assign miso_line = spi_miso_oe ? spi_miso : ~spi_miso;

  // ****************
  // Helpers
  // ****************
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
    if (watch && irq_out !== 1'b1)
      drop <= 1'b1;

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk_word(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_irq(input logic e);
    check_count++;
    if (irq_out !== e)
    begin
      error_cnt++;
      $display("ERROR irq_out expected %b seen %b", e, irq_out);
    end
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] e);
    i_host.xfer(c, 8, r);
    chk_word("reply", e, r);
  endtask

  task automatic pulse(input int i);
    flt[i] <= 1'b1;
    tick(8);
    flt[i] <= 1'b0;
    tick(8);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    tick(20000);
    error_cnt++;
    finish_test();
  end

  // ****************
  // Tests
  // ****************
  initial
  begin
    reset_n = 1'b0;
    flt = 8'h00;
    pc = 3'h0;
    dc = 3'h0;
    blank = 1'b0;
    full_on = 1'b0;
    watch = 1'b0;
    drop = 1'b0;
    error_cnt = 0;
    check_count = 0;
    tick(20);
    reset_n <= 1'b1;
    tick(8);
    chk_irq(1'b1);
    chk_word("miso_oe", 8'h00, {7'h00, spi_miso_oe});
    cmd(8'h00, 8'h80);
    cmd(8'h00, 8'h80);
    cmd(8'h78, 8'h80);
    chk_irq(1'b0);
    cmd(8'h1D, 8'h00);
    cmd(8'h02, 8'hA5);
    cmd(8'h03, 8'h3C);
    cmd(8'h00, 8'hC3);
    cmd(8'h01, 8'h00);
    cmd(8'h45, 8'hA5);
    cmd(8'h00, 8'h00);
    $display("test query done");
    for (b = 0; b < 7; b++)
    begin
      if (b == 4 || b == 5)
        continue;
      hi = (b < 4) ? 4'h0 : 4'h1;
      nib = 4'h1 << (b % 4);
      w = 8'h01 << b;
      pulse(b);
      chk_irq(1'b1);
      cmd(8'h00, w);
      cmd({4'h2 | hi, ~nib}, w);
      chk_irq(1'b0);
      cmd({4'h2 | hi, 4'hF}, w);
      chk_irq(1'b1);
      cmd({4'h6 | hi, nib}, w);
      chk_irq(1'b0);
    end
    $display("test sources done");
    pulse(0);
    i_host.xfer(8'h61, 5, r);
    cmd(8'h00, 8'h21);
    cmd(8'h61, 8'h21);
    cmd(8'h72, 8'h20);
    chk_irq(1'b0);
    $display("test framing done");
    flt[0] <= 1'b1;
    tick(8);
    cmd(8'h61, 8'h01);
    chk_irq(1'b1);
    cmd(8'h00, 8'h01);
    flt[0] <= 1'b0;
    cmd(8'h61, 8'h01);
    chk_irq(1'b0);
    $display("test active done");
    pulse(1);
    pulse(3);
    watch <= 1'b1;
    cmd(8'h62, 8'h0A);
    watch <= 1'b0;
    chk_word("irq_drop", 8'h00, {7'h00, drop});
    cmd(8'h68, 8'h08);
    chk_irq(1'b0);
    $display("test multiple done");
    fork
      i_host.xfer(8'h61, 8, r);
      begin
        tick(30);
        flt[0] <= 1'b1;
        tick(8);
        flt[0] <= 1'b0;
      end
    join
    chk_word("reply", 8'h00, r);
    cmd(8'h00, 8'h01);
    cmd(8'h61, 8'h01);
    $display("test mid_frame done");
    blank <= 1'b1;
    dc <= 3'h5;
    pc <= 3'h5;
    tick(10);
    blank <= 1'b0;
    tick(10);
    chk_irq(1'b0);
    pc <= 3'h4;
    blank <= 1'b1;
    tick(10);
    chk_irq(1'b0);
    blank <= 1'b0;
    full_on <= 1'b1;
    tick(10);
    chk_irq(1'b0);
    full_on <= 1'b0;
    tick(10);
    chk_irq(1'b1);
    pc <= 3'h0;
    dc <= 3'h0;
    cmd(8'h00, 8'h10);
    cmd(8'h71, 8'h10);
    chk_irq(1'b0);
    $display("test phase done");
    cmd(8'h30, 8'h00);
    cmd(8'h01, 8'h00);
    reset_n <= 1'b0;
    tick(3);
    chk_irq(1'b0);
    reset_n <= 1'b1;
    tick(8);
    chk_irq(1'b1);
    i_host.service(r);
    chk_word("reply", 8'h80, r);
    chk_irq(1'b0);
    $display("test reset done");
    finish_test();
  end
endmodule
`default_nettype wire
